// File: design/fsr_regs.sv
/*
 * Status word and configuration byte of a serial flash, with the serial
 * command front end for write enable, status and configuration reads,
 * ready poll, status write and suspend/resume bookkeeping.
 * Assumes the array engine runs on REF_CLK and reports its busy levels.
 */
`timescale 1ns/1ps
`default_nettype none
module fsr_regs
    import fsr_pkg::*;
#(
    parameter int TW_NS = fsr_pkg::TW_DEFAULT_NS,
    parameter logic DUAL_PAGE_RESET = 1'b0
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // Serial bus pins.
    input wire logic SPI_CS_N,
    input wire logic SPI_SCLK,
    input wire logic SPI_SI,
    output logic SPI_SO_O,
    output logic SPI_SO_OE,
    // Shared pins.
    input wire logic WP_N,
    input wire logic PAUSE_N,
    // Array engine side.
    input wire logic ARRAY_PROGRAM_BUSY,
    input wire logic ARRAY_ERASE_BUSY,
    input wire logic ARRAY_WEL_CLEAR,
    output logic WRITE_ENABLE_LATCH,
    output logic SUSPEND_PULSE,
    output logic RESUME_PULSE,
    // Configuration seen by the array.
    output logic [4:0] BLOCK_PROTECT_FIELD,
    output logic PROTECT_COMPLEMENT,
    output logic [2:0] SECURITY_LOCK,
    output logic QUAD_PINS_EN,
    output logic PAUSE_ACTIVE,
    output logic [8:0] PAGE_WRAP_MASK,
    output logic DUAL_PAGE_ERASE
);
    import fsr_pkg::*;

    localparam int TW_CYCLES_RAW = TW_NS / CLK_PERIOD_NS;
    localparam int TW_CYCLES = (TW_CYCLES_RAW < 1) ? 1 : TW_CYCLES_RAW;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    fsr_pin_if cs_p ();
    fsr_pin_if sck_p ();
    fsr_pin_if si_p ();
    fsr_pin_if wp_p ();
    fsr_pin_if pause_p ();
    assign cs_p.raw = SPI_CS_N;
    assign sck_p.raw = SPI_SCLK;
    assign si_p.raw = SPI_SI;
    assign wp_p.raw = WP_N;
    assign pause_p.raw = PAUSE_N;

    fsr_sync #(.RESET_LEVEL(1'b1)) u_cs (.clk(REF_CLK), .rst_n(RESET_N), .pin(cs_p));
    fsr_sync #(.RESET_LEVEL(1'b0)) u_sck (.clk(REF_CLK), .rst_n(RESET_N), .pin(sck_p));
    fsr_sync #(.RESET_LEVEL(1'b0)) u_si (.clk(REF_CLK), .rst_n(RESET_N), .pin(si_p));
    fsr_sync #(.RESET_LEVEL(1'b1)) u_wp (.clk(REF_CLK), .rst_n(RESET_N), .pin(wp_p));
    fsr_sync #(.RESET_LEVEL(1'b1)) u_pause (.clk(REF_CLK), .rst_n(RESET_N), .pin(pause_p));

    ////////////////////////////////////////////////////////////////////////
    // Held register bits. Reset stands for the power cycle.
    logic [1:0] protect_mode_reg;
    logic quad_enable_reg;
    logic [4:0] block_protect_reg;
    logic [2:0] security_lock_reg;
    logic complement_reg;
    logic erase_suspended_reg;
    logic program_suspended_reg;
    logic dual_page_reg;
    logic wel_reg;
    logic wr_busy_reg;
    logic [31:0] tw_count_reg;

    logic write_in_progress;
    logic wp_low;
    logic pause_low;
    logic status_locked;
    logic [15:0] status_word;
    logic [7:0] config_byte;

    // With quad enabled the protect and pause pins carry data instead.
    assign wp_low = ~quad_enable_reg & ~wp_p.level;
    assign pause_low = ~quad_enable_reg & ~pause_p.level;
    assign write_in_progress = wr_busy_reg | ARRAY_PROGRAM_BUSY | ARRAY_ERASE_BUSY;

    always_comb
    begin
        case (protect_mode_reg)
            SRP_SOFTWARE: status_locked = 1'b0;
            SRP_PIN: status_locked = wp_low;
            SRP_LOCKDOWN: status_locked = 1'b1;
            SRP_ONE_TIME: status_locked = 1'b1;
            default: status_locked = 1'b1;
        endcase
    end

    always_comb
    begin
        status_word = 16'h0000;
        status_word[SB_WIP] = write_in_progress;
        status_word[SB_WEL] = wel_reg;
        status_word[SB_BP_HI:SB_BP_LO] = block_protect_reg;
        status_word[SB_STATUS_PROTECT_LO] = protect_mode_reg[0];
        status_word[SB_STATUS_PROTECT_HI] = protect_mode_reg[1];
        status_word[SB_QE] = quad_enable_reg;
        status_word[SB_PSUS] = program_suspended_reg;
        status_word[SB_LOCK_HI:SB_LOCK_LO] = security_lock_reg;
        status_word[SB_CMP] = complement_reg;
        status_word[SB_ESUS] = erase_suspended_reg;
        config_byte = 8'h00;
        config_byte[CB_DUAL_PAGE] = dual_page_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial front end.
    fsr_state_e state_reg;
    logic [4:0] bit_count_reg;
    logic [15:0] shift_in_reg;
    logic [7:0] command_reg;
    logic [7:0] shift_out_reg;
    logic [2:0] out_count_reg;
    logic so_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] opcode_now;
    logic [7:0] read_byte;
    logic end_frame;
    logic write_status_command_ok;
    logic [15:0] wide_word;

    // Clock edges are held off while the pause pin is active.
    assign sclk_rise = sck_p.rise & ~pause_low;
    assign sclk_fall = sck_p.fall & ~pause_low;
    assign opcode_now = {shift_in_reg[6:0], si_p.level};
    assign end_frame = cs_p.rise;
    assign read_byte = (command_reg == OPC_READ_CONFIG) ? config_byte :
        (command_reg == OPC_READ_STATUS_HI) ? status_word[15:8] : status_word[7:0];

    // Status write commits only at an exact byte boundary with the latch set.
    assign write_status_command_ok = end_frame && (state_reg == FSR_DATA) && wel_reg && !status_locked
        && !wr_busy_reg && (bit_count_reg == BITS_BYTE || bit_count_reg == BITS_WORD);
    // The first data byte is always S7..S0, so a long write arrives low byte first.
    assign wide_word = {shift_in_reg[7:0], shift_in_reg[15:8]};

    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state_reg <= FSR_IDLE;
            bit_count_reg <= BITS_ZERO;
            shift_in_reg <= 16'h0000;
            command_reg <= 8'h00;
        end
        else if (cs_p.level)
        begin
            state_reg <= FSR_IDLE;
            bit_count_reg <= BITS_ZERO;
        end
        else if (state_reg == FSR_IDLE)
        begin
            state_reg <= FSR_OPCODE;
            bit_count_reg <= BITS_ZERO;
        end
        else if (sclk_rise)
        begin
            shift_in_reg <= {shift_in_reg[14:0], si_p.level};
            bit_count_reg <= (bit_count_reg == BITS_WORD) ? bit_count_reg : bit_count_reg + 5'h01;
            if (state_reg == FSR_OPCODE && bit_count_reg == BITS_OPCODE - 5'h01)
            begin
                command_reg <= opcode_now;
                bit_count_reg <= BITS_ZERO;
                case (opcode_now)
                    OPC_WRITE_STATUS: state_reg <= FSR_DATA;
                    OPC_READ_STATUS_LO: state_reg <= FSR_SHOUT;
                    OPC_READ_STATUS_HI: state_reg <= FSR_SHOUT;
                    OPC_READ_CONFIG: state_reg <= FSR_SHOUT;
                    OPC_READY_POLL: state_reg <= FSR_POLL;
                    default: state_reg <= FSR_SKIP;
                endcase
            end
            else if (state_reg == FSR_DATA && bit_count_reg == BITS_WORD)
            begin
                state_reg <= FSR_SKIP;
                bit_count_reg <= BITS_WORD + 5'h01;
            end
        end
    end

    // Output shifter: data changes on the falling clock edge.
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            shift_out_reg <= 8'h00;
            out_count_reg <= 3'h0;
            so_reg <= 1'b0;
        end
        else if (state_reg == FSR_POLL)
        begin
            // Busy only falls during an operation, so the line only falls.
            so_reg <= write_in_progress;
        end
        else if (state_reg == FSR_SHOUT && sclk_fall)
        begin
            if (out_count_reg == 3'h0)
            begin
                so_reg <= read_byte[7];
                shift_out_reg <= {read_byte[6:0], 1'b0};
            end
            else
            begin
                so_reg <= shift_out_reg[7];
                shift_out_reg <= {shift_out_reg[6:0], 1'b0};
            end
            out_count_reg <= (out_count_reg == OUT_LAST) ? 3'h0 : out_count_reg + 3'h1;
        end
        else if (state_reg != FSR_SHOUT)
        begin
            out_count_reg <= 3'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status writes and the self-timed cycle.
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            protect_mode_reg <= RST_PROTECT_MODE;
            quad_enable_reg <= RST_BIT;
            block_protect_reg <= RST_BLOCK_PROTECT;
            security_lock_reg <= RST_SECURITY_LOCK;
            complement_reg <= RST_BIT;
        end
        else if (write_status_command_ok)
        begin
            // Suspend bits, latch and busy are never taken from the data.
            if (bit_count_reg == BITS_BYTE)
            begin
                protect_mode_reg <= {1'b0, shift_in_reg[SB_STATUS_PROTECT_LO]};
                block_protect_reg <= shift_in_reg[SB_BP_HI:SB_BP_LO];
                quad_enable_reg <= 1'b0;
                complement_reg <= 1'b0;
            end
            else
            begin
                protect_mode_reg <= {wide_word[SB_STATUS_PROTECT_HI], wide_word[SB_STATUS_PROTECT_LO]};
                block_protect_reg <= wide_word[SB_BP_HI:SB_BP_LO];
                quad_enable_reg <= wide_word[SB_QE];
                complement_reg <= wide_word[SB_CMP];
                security_lock_reg <= security_lock_reg
                    | wide_word[SB_LOCK_HI:SB_LOCK_LO];
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wr_busy_reg <= 1'b0;
            tw_count_reg <= 32'h00000000;
        end
        else if (write_status_command_ok)
        begin
            wr_busy_reg <= 1'b1;
            tw_count_reg <= 32'(TW_CYCLES - 1);
        end
        else if (wr_busy_reg)
        begin
            if (tw_count_reg == 32'h00000000)
                wr_busy_reg <= 1'b0;
            else
                tw_count_reg <= tw_count_reg - 32'h00000001;
        end
    end

    // Write-enable latch; a new write enable wins over a clear.
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            wel_reg <= 1'b0;
        else if (end_frame && state_reg == FSR_SKIP && bit_count_reg == BITS_ZERO
            && command_reg == OPC_WRITE_ENABLE)
            wel_reg <= 1'b1;
        else if (end_frame && state_reg == FSR_SKIP && bit_count_reg == BITS_ZERO
            && command_reg == OPC_WRITE_DISABLE)
            wel_reg <= 1'b0;
        else if ((wr_busy_reg && tw_count_reg == 32'h00000000) || ARRAY_WEL_CLEAR)
            wel_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Suspend and resume bookkeeping.
    logic suspend_cmd;
    logic resume_cmd;
    assign suspend_cmd = end_frame && state_reg == FSR_SKIP && bit_count_reg == BITS_ZERO
        && (command_reg == OPC_SUSPEND_A || command_reg == OPC_SUSPEND_B);
    assign resume_cmd = end_frame && state_reg == FSR_SKIP && bit_count_reg == BITS_ZERO
        && (command_reg == OPC_RESUME_A || command_reg == OPC_RESUME_B);

    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            erase_suspended_reg <= RST_BIT;
            program_suspended_reg <= RST_BIT;
            SUSPEND_PULSE <= 1'b0;
            RESUME_PULSE <= 1'b0;
        end
        else
        begin
            SUSPEND_PULSE <= suspend_cmd;
            RESUME_PULSE <= resume_cmd;
            if (resume_cmd)
            begin
                erase_suspended_reg <= 1'b0;
                program_suspended_reg <= 1'b0;
            end
            else if (suspend_cmd)
            begin
                if (ARRAY_ERASE_BUSY)
                    erase_suspended_reg <= 1'b1;
                if (ARRAY_PROGRAM_BUSY)
                    program_suspended_reg <= 1'b1;
            end
        end
    end

    // The dual-page bit is only loaded at power-up here.
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            dual_page_reg <= DUAL_PAGE_RESET;
        else
            dual_page_reg <= dual_page_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign SPI_SO_O = so_reg;
    assign SPI_SO_OE = (state_reg == FSR_POLL) || (state_reg == FSR_SHOUT);
    assign WRITE_ENABLE_LATCH = wel_reg;
    assign BLOCK_PROTECT_FIELD = block_protect_reg;
    assign PROTECT_COMPLEMENT = complement_reg;
    assign SECURITY_LOCK = security_lock_reg;
    assign QUAD_PINS_EN = quad_enable_reg;
    assign PAUSE_ACTIVE = pause_low;
    assign PAGE_WRAP_MASK = dual_page_reg ? WRAP_MASK_512 : WRAP_MASK_256;
    assign DUAL_PAGE_ERASE = dual_page_reg;
endmodule : fsr_regs
`default_nettype wire

// File: design/fsr_pkg.sv
/*
 * Shared constants of the flash status and configuration register block:
 * opcodes, status bit positions, reset values and timing figures.
 * Assumes a 40 MHz system clock and a serial bus in clock mode 0 or 3.
 */
// Contract
// - Protect bits 00: write allowed when latch set.
// - Protect bits 01: pin low locks, high allows.
// - Protect bits 10: locked until power cycle.
// - Protect bits 11: status permanently locked; code reloads 00 on reset.
// - Quad enable turns protect/pause pins into data.
// - Three lock bits set once, never cleared; code clears them on reset.
// - Complement bit held, default zero.
// - Suspend sets matching suspended bit.
// - Resume or power cycle clears suspended bits.
// - Opcode 15h shifts configuration byte out anytime.
// - Dual-page bit selects 256 or 512 wrap.
// - Dual-page page erase covers 512 bytes.
// - Opcode 25h drives busy level continuously.
// - Poll output only falls, never rises.
// - Chip select high ends poll, output released.
// - Write status needs write-enable latch set.
// - Write leaves S15, S10, S1, S0 alone.
// - Only 8 or 16 data bits accepted.
// - Eight-bit write clears complement, quad, upper protect.
// - Valid write starts timed cycle, then clears.
// - Hardware protected mode ignores write status.
// - Latch clear rejects write, program, erase.
// - S0 reads one while any operation runs.
package fsr_pkg;
    // Opcodes.
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_READ_STATUS_LO = 8'h05;
    localparam logic [7:0] OPC_READ_STATUS_HI = 8'h35;
    localparam logic [7:0] OPC_READ_CONFIG = 8'h15;
    localparam logic [7:0] OPC_READY_POLL = 8'h25;
    localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OPC_SUSPEND_A = 8'h75;
    localparam logic [7:0] OPC_SUSPEND_B = 8'hB0;
    localparam logic [7:0] OPC_RESUME_A = 8'h7A;
    localparam logic [7:0] OPC_RESUME_B = 8'h30;
    // Status word bit positions.
    localparam int SB_WIP = 0;
    localparam int SB_WEL = 1;
    localparam int SB_BP_LO = 2;
    localparam int SB_BP_HI = 6;
    localparam int SB_STATUS_PROTECT_LO = 7;
    localparam int SB_STATUS_PROTECT_HI = 8;
    localparam int SB_QE = 9;
    localparam int SB_PSUS = 10;
    localparam int SB_LOCK_LO = 11;
    localparam int SB_LOCK_HI = 13;
    localparam int SB_CMP = 14;
    localparam int SB_ESUS = 15;
    localparam int CB_DUAL_PAGE = 7;
    // Bit counts and widths.
    localparam logic [4:0] BITS_OPCODE = 5'h08;
    localparam logic [4:0] BITS_BYTE = 5'h08;
    localparam logic [4:0] BITS_WORD = 5'h10;
    localparam logic [4:0] BITS_ZERO = 5'h00;
    localparam logic [2:0] OUT_LAST = 3'h7;
    localparam logic [8:0] WRAP_MASK_256 = 9'h0FF;
    localparam logic [8:0] WRAP_MASK_512 = 9'h1FF;
    // Reset values of the held bits.
    localparam logic [4:0] RST_BLOCK_PROTECT = 5'h00;
    localparam logic [2:0] RST_SECURITY_LOCK = 3'h0;
    localparam logic [1:0] RST_PROTECT_MODE = 2'h0;
    localparam logic RST_BIT = 1'b0;
    // Protection modes {hi, lo}.
    localparam logic [1:0] SRP_SOFTWARE = 2'h0;
    localparam logic [1:0] SRP_PIN = 2'h1;
    localparam logic [1:0] SRP_LOCKDOWN = 2'h2;
    localparam logic [1:0] SRP_ONE_TIME = 2'h3;
    // Timing.
    localparam int CLK_PERIOD_NS = 25;
    localparam int TW_DEFAULT_NS = 8000000;

    typedef enum logic [2:0] {
        FSR_IDLE = 3'h0,
        FSR_OPCODE = 3'h1,
        FSR_DATA = 3'h3,
        FSR_SHOUT = 3'h2,
        FSR_POLL = 3'h6,
        FSR_SKIP = 3'h7
    } fsr_state_e;
endpackage : fsr_pkg

// File: design/fsr_pin_if.sv
/*
 * Carrier between a pin synchroniser and its user: raw pin, settled level
 * and one-cycle edge pulses. Assumes a single system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface fsr_pin_if;
    logic raw;
    logic level;
    logic rise;
    logic fall;
    modport sync (input raw, output level, rise, fall);
    modport user (output raw, input level, rise, fall);
endinterface : fsr_pin_if
`default_nettype wire

// File: design/fsr_sync.sv
/*
 * Three-flop synchroniser for one asynchronous pin with edge pulses.
 * Assumes the pin changes slower than a few system clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module fsr_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Pin side and settled side.
    fsr_pin_if.sync pin
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic level_next;

    // A change counts only once the second and third stages agree.
    assign level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= RESET_LEVEL;
            s2_reg <= RESET_LEVEL;
            s3_reg <= RESET_LEVEL;
            level_reg <= RESET_LEVEL;
        end
        else
        begin
            s1_reg <= pin.raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign pin.level = level_reg;
    assign pin.rise = level_next & ~level_reg;
    assign pin.fall = ~level_next & level_reg;
endmodule : fsr_sync
`default_nettype wire

// File: bench/fsr_regs_properties.sv
/* Assertion checker for fsr_regs, bound below the module.
   Assumes all ports are sampled on REF_CLK. */
`timescale 1ns/1ps
`default_nettype none
module fsr_regs_properties (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // Serial pins.
    input wire logic SPI_CS_N,
    input wire logic SPI_SCLK,
    input wire logic SPI_SO_O,
    input wire logic SPI_SO_OE,
    // Register outputs.
    input wire logic WRITE_ENABLE_LATCH,
    input wire logic SUSPEND_PULSE,
    input wire logic [4:0] BLOCK_PROTECT_FIELD,
    input wire logic [2:0] SECURITY_LOCK,
    input wire logic QUAD_PINS_EN,
    input wire logic PAUSE_ACTIVE,
    input wire logic [8:0] PAGE_WRAP_MASK,
    input wire logic DUAL_PAGE_ERASE
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////
    // Pins pass a synchroniser, so a few cycles of slack are allowed.
    AST_OE_RELEASE: assert property (SPI_CS_N [*7] |-> !SPI_SO_OE)
        else $error("output still enabled");
    AST_POLL_NO_RISE:
        assert property ((SPI_SO_OE && $stable(SPI_SCLK)) [*7] |-> !$rose(SPI_SO_O))
        else $error("poll output rose");
    AST_LOCK_KEEP: assert property (($past(SECURITY_LOCK) & ~SECURITY_LOCK) == 3'h0)
        else $error("lock bit cleared");
    AST_LATCH_SET: assert property ($rose(WRITE_ENABLE_LATCH) |-> $past(SPI_CS_N, 2))
        else $error("latch set inside a frame");
    AST_PROTECT_WRITE:
        assert property ($changed(BLOCK_PROTECT_FIELD) |-> WRITE_ENABLE_LATCH && $past(SPI_CS_N, 2))
        else $error("protect field changed without latch");
    AST_SUSPEND_ONE:
        assert property (SUSPEND_PULSE |-> $past(SPI_CS_N, 2) ##1 !SUSPEND_PULSE)
        else $error("bad suspend pulse");
    AST_WRAP_MASK:
        assert property (PAGE_WRAP_MASK == (DUAL_PAGE_ERASE ? 9'h1FF : 9'h0FF))
        else $error("wrap mask wrong");
    AST_QUAD_PINS: assert property (QUAD_PINS_EN |-> !PAUSE_ACTIVE)
        else $error("pause active in quad mode");
endmodule : fsr_regs_properties
bind fsr_regs fsr_regs_properties fsr_regs_properties_i (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .SPI_CS_N(SPI_CS_N), .SPI_SCLK(SPI_SCLK),
    .SPI_SO_O(SPI_SO_O), .SPI_SO_OE(SPI_SO_OE), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
    .SUSPEND_PULSE(SUSPEND_PULSE), .BLOCK_PROTECT_FIELD(BLOCK_PROTECT_FIELD),
    .SECURITY_LOCK(SECURITY_LOCK), .QUAD_PINS_EN(QUAD_PINS_EN), .PAUSE_ACTIVE(PAUSE_ACTIVE),
    .PAGE_WRAP_MASK(PAGE_WRAP_MASK), .DUAL_PAGE_ERASE(DUAL_PAGE_ERASE)
);
`default_nettype wire

// File: bench/fsr_host.sv
/* Host controller model: clock mode 0 frames, 200 ns serial clock.
   Assumes one bench process calls its tasks after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module fsr_host (
    // Bench clock.
    input wire logic clk,
    // Serial pins.
    output logic cs_n,
    output logic sclk,
    output logic si,
    input wire logic so
);
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // Mode 0 needs no dummy bit after the poll opcode; select stays low.
    task automatic xfer(input logic [7:0] opc, input logic [15:0] dat, input int nb,
        output logic [15:0] rd);
        logic [23:0] sh;
        sh = {opc, dat};
        rd = 16'h0000;
        cs_n <= 1'b0;
        tick(6);
        for (int i = 0; i < 8 + nb; i++)
        begin
            si <= sh[23 - i];
            tick(4);
            sclk <= 1'b1;
            tick(2);
            // Sampled mid-phase so a late output update cannot race it.
            @(negedge clk);
            rd = {rd[14:0], so};
            tick(2);
            sclk <= 1'b0;
        end
    endtask : xfer
    // A released data line shows the inverse, never a stale copy.
    task automatic done;
        tick(2);
        cs_n <= 1'b1;
        si <= ~si;
        tick(8);
    endtask : done
endmodule : fsr_host
`default_nettype wire

// File: bench/fsr_regs_tb_top.sv
/* Self-checking bench of fsr_regs: status write rows, then suspend codes.
   Assumes the host model drives the serial pins. */
`timescale 1ns/1ps
`default_nettype none
module fsr_regs_tb_top;
    import fsr_pkg::*;
    // Flags are {reset, write enable, protect pin, accepted}.
    typedef struct packed {
        logic rst;
        logic write_enable_command;
        logic wp;
        logic acc;
        logic [7:0] nb;
        logic [15:0] val;
        logic [15:0] exp;
    } fsr_row_s;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic wp_n = 1'b1;
    logic pause_n = 1'b1;
    logic prog_busy = 1'b0;
    logic erase_busy = 1'b0;
    logic cs_n, sclk, si, so_o, so_oe, write_enable_latch, cmp, quad, pact, sus_p, res_p, dpe;
    logic wel_clr = 1'b0;
    logic [3:0] n_sus, n_res;
    logic [4:0] bp;
    logic [2:0] lock;
    logic [8:0] wrap;
    logic [15:0] rd;
    logic [7:0] lo, hi;
    int bad_count = 0;
    int n_tests = 0;
    int k;
    fsr_row_s rows [11] = '{44'h5_10_667F_627C, 44'h5_08_0008_2008, 44'h7_10_1084_3084,
        44'h4_10_0000_3084, 44'h6_0C_0000_3084, 44'h7_10_0004_3004, 44'h2_10_0000_3004,
        44'h7_10_0100_3100, 44'h6_10_0000_3100, 44'hF_10_0180_0180, 44'h6_10_0000_0180};
    logic [17:0] sus_tab [4] = '{18'h2_75_81, 18'h0_7A_01, 18'h1_B0_05, 18'h0_30_01};
    always #12.5 ref_clk = ~ref_clk;
    // Pulses are counted so that each suspend or resume frame must give exactly one.
    always @(posedge ref_clk)
    begin
        n_sus <= reset_n ? n_sus + {3'h0, sus_p} : 4'h0;
        n_res <= reset_n ? n_res + {3'h0, res_p} : 4'h0;
    end
    // A short write cycle of 400 clocks keeps the run brief yet outlasts a read frame.
    fsr_regs #(.TW_NS(10000), .DUAL_PAGE_RESET(1'b0)) fsr_regs_i (
        .REF_CLK(ref_clk), .RESET_N(reset_n), .SPI_CS_N(cs_n), .SPI_SCLK(sclk),
        .SPI_SI(si), .SPI_SO_O(so_o), .SPI_SO_OE(so_oe), .WP_N(wp_n), .PAUSE_N(pause_n),
        .ARRAY_PROGRAM_BUSY(prog_busy), .ARRAY_ERASE_BUSY(erase_busy),
        .ARRAY_WEL_CLEAR(wel_clr), .WRITE_ENABLE_LATCH(write_enable_latch), .SUSPEND_PULSE(sus_p),
        .RESUME_PULSE(res_p), .BLOCK_PROTECT_FIELD(bp), .PROTECT_COMPLEMENT(cmp),
        .SECURITY_LOCK(lock), .QUAD_PINS_EN(quad), .PAUSE_ACTIVE(pact),
        .PAGE_WRAP_MASK(wrap), .DUAL_PAGE_ERASE(dpe)
    );
    // A released output line shows the inverse of its last value to the host.
    fsr_host fsr_host_i (.clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .si(si),
        .so(so_oe ? so_o : ~so_o));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic rdreg(input logic [7:0] opc, output logic [7:0] v);
        fsr_host_i.xfer(opc, 16'h0000, 8, rd);
        fsr_host_i.done();
        v = rd[7:0];
    endtask : rdreg
    task automatic do_reset;
        reset_n <= 1'b0;
        fsr_host_i.tick(10);
        reset_n <= 1'b1;
        fsr_host_i.tick(4);
    endtask : do_reset
    ////////////////////////////////////////////////////////////
    initial
    begin
        do_reset();
        check({write_enable_latch, bp, cmp, lock, quad, so_oe, wrap, dpe}, 24'h0001FE);
        foreach (rows[i])
        begin
            if (rows[i].rst)
                do_reset();
            wp_n <= rows[i].wp;
            if (rows[i].write_enable_command)
            begin
                fsr_host_i.xfer(8'h06, 16'h0000, 0, rd);
                fsr_host_i.done();
            end
            fsr_host_i.xfer(8'h01, {rows[i].val[7:0], rows[i].val[15:8]}, rows[i].nb, rd);
            fsr_host_i.done();
            rdreg(8'h15, lo);
            check(lo, 24'h000000);
            fsr_host_i.xfer(8'h25, 16'h0000, 0, rd);
            pause_n <= 1'b0;
            fsr_host_i.tick(6);
            @(negedge ref_clk);
            check(so_o, rows[i].acc);
            for (k = 0; k < 600 && so_o !== 1'b0; k++)
                @(negedge ref_clk);
            if (k == 600)
            begin
                bad_count++;
                finish_test();
            end
            check({pact, so_oe, so_o}, {~rows[i].exp[9], 2'b10});
            fsr_host_i.tick(1);
            pause_n <= 1'b1;
            fsr_host_i.done();
            check(so_oe, 24'h000000);
            rdreg(8'h05, lo);
            rdreg(8'h35, hi);
            check({hi, lo}, rows[i].exp | {14'h0, rows[i].write_enable_command & ~rows[i].acc, 1'b0});
            check({cmp, lock, quad, bp}, {rows[i].exp[14:11], rows[i].exp[9], rows[i].exp[6:2]});
            $display("row %0d done", i);
        end
        foreach (sus_tab[j])
        begin
            {erase_busy, prog_busy} <= sus_tab[j][17:16];
            fsr_host_i.xfer(sus_tab[j][15:8], 16'h0000, 0, rd);
            fsr_host_i.done();
            rdreg(8'h35, hi);
            rdreg(8'h05, lo);
            check({hi, lo[0]}, {sus_tab[j][7:0], |sus_tab[j][17:16]});
            $display("suspend step %0d done", j);
        end
        check({n_sus, n_res}, 24'h000022);
        fsr_host_i.xfer(8'h06, 16'h0000, 0, rd);
        fsr_host_i.done();
        check(write_enable_latch, 24'h000001);
        wel_clr <= 1'b1;
        fsr_host_i.tick(1);
        wel_clr <= 1'b0;
        fsr_host_i.tick(1);
        check(write_enable_latch, 24'h000000);
        $display("latch clear done");
        finish_test();
    end
endmodule : fsr_regs_tb_top
`default_nettype wire
